/* File: shared/stc_pkg.sv */
// Constants for the SCSI transfer control block
package stc_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] STC_TRANSFER_CONTROL_OFFSET = 8'h52;
	localparam logic [7:0] STC_TRANSFER_CONTROL_RESET = 8'h00;
	// ==========================================================
	// Field positions
	localparam int STC_DMA_START_BIT = 1;
	localparam int STC_PIO_START_BIT = 2;
	localparam int STC_DIRECTION_BIT = 3;
	localparam int STC_COUNT_LSB = 4;
	localparam int STC_COUNT_MSB = 7;
	localparam int STC_COUNT_WIDTH = 4;
	localparam logic [3:0] STC_COUNT_RESET = 4'h0;
	localparam logic [3:0] STC_COUNT_ONE = 4'h1;
	// ==========================================================
	// Programmed transfer sequencer states
	typedef enum logic [0:0] {
		STC_PIO_IDLE = 1'b0,
		STC_PIO_RUN = 1'b1
	} stc_pio_state_type;
endpackage

/* File: shared/stc_count_if.sv */
// Carrier between the control register and the byte down-counter
`timescale 1ns/1ps
`default_nettype none
interface stc_count_if;
	logic load;
	logic [3:0] load_value;
	logic clear;
	logic dec;
	logic [3:0] count;
	logic last;
	modport ctrl (output load, output load_value, output clear, output dec, input count,
		input last);
	modport counter (input load, input load_value, input clear, input dec, output count,
		output last);
endinterface
`default_nettype wire

/* File: src/stc_byte_counter.sv */
// Programmed byte down-counter with load, clear and decrement
`timescale 1ns/1ps
`default_nettype none
module stc_byte_counter (
	input wire logic sys_clk,
	input wire logic rst,
	stc_count_if.counter cnt
);
	logic [3:0] count_r;
	logic [3:0] count_nxt;

	// ==========================================================
	// Next count: clear beats load, load beats decrement
	always_comb begin
		count_nxt = count_r;
		if (cnt.clear) begin
			count_nxt = stc_pkg::STC_COUNT_RESET;
		end else if (cnt.load) begin
			count_nxt = cnt.load_value;
		end else if (cnt.dec && (count_r != stc_pkg::STC_COUNT_RESET)) begin
			count_nxt = count_r - stc_pkg::STC_COUNT_ONE; // [R11]
		end
	end

	// Register only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_r <= stc_pkg::STC_COUNT_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end

	// Plain unsigned binary, bit 3 of the count is the top bit
	assign cnt.count = count_r; // [R8]
	assign cnt.last = (count_r == stc_pkg::STC_COUNT_ONE);
endmodule
`default_nettype wire

/* File: src/stc_transfer_control.sv */
// Transfer control register: launches and tracks DMA and programmed SCSI transfers
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Chip, bus or software reset clears register
// R2: DMA start bit launches DMA in set direction
// R3: DMA start clears on done, mismatch, halt; halt only clears it in target mode
// R4: Programmed start moves count bytes through FIFO
// R5: Programmed start clears on done or mismatch
// R6: Direction set sends, clear receives, both modes
// R7: Count write loads, read returns running count
// R8: Count is unsigned binary, zero to fifteen
// R9: Software reset stops work, floats SCSI signals
// R10: Firmware releases FIFO clear before FIFO use
// R11: Each byte decrements count; zero means done
module stc_transfer_control (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic scsi_bus_reset,
	input wire logic host_buffer_reset,
	input wire logic initiator_mode,
	input wire logic phase_mismatch,
	input wire logic scsi_request,
	input wire logic dma_halt,
	input wire logic dma_done,
	input wire logic byte_done,
	output logic dma_active,
	output logic pio_active,
	output logic bus_transfer_direction,
	output logic scsi_drive_enable
);
	// ==========================================================
	// Register state
	logic dma_start_r;
	logic dma_start_nxt;
	logic pio_start_r;
	logic pio_start_nxt;
	logic direction_r;
	logic direction_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic drive_en_r;
	logic drive_en_nxt;
	stc_pkg::stc_pio_state_type pio_state_r;
	stc_pkg::stc_pio_state_type pio_state_nxt;

	// ==========================================================
	// Decode and shared terms
	logic hit;
	logic wr_hit;
	logic rd_hit;
	logic any_reset;
	logic mismatch_abort;
	logic pio_finish;
	logic [3:0] wr_count;

	stc_count_if cnt ();

	assign hit = (reg_addr == stc_pkg::STC_TRANSFER_CONTROL_OFFSET);
	assign wr_hit = reg_write && hit;
	assign rd_hit = reg_read && hit;
	assign wr_count = reg_wdata[stc_pkg::STC_COUNT_MSB:stc_pkg::STC_COUNT_LSB];

	// Bus reset and software reset act like a synchronous clear of the register
	assign any_reset = scsi_bus_reset || host_buffer_reset; // [R1]

	// Initiator only: a phase change with REQ up aborts the transfer
	assign mismatch_abort = initiator_mode && phase_mismatch && scsi_request; // [R3] [R5]

	// Done when the last byte goes, or when started with nothing to move
	assign pio_finish = (pio_state_r == stc_pkg::STC_PIO_RUN) &&
		((byte_done && cnt.last) || (cnt.count == stc_pkg::STC_COUNT_RESET)); // [R11]

	// ==========================================================
	// Counter control
	always_comb begin
		cnt.clear = any_reset; // [R1]
		cnt.load = wr_hit && !any_reset; // [R7]
		cnt.load_value = wr_count;
		// Bytes only count while a programmed transfer is running
		cnt.dec = byte_done && (pio_state_r == stc_pkg::STC_PIO_RUN) && !cnt.load; // [R11]
	end

	stc_byte_counter u_counter (
		.sys_clk(sys_clk),
		.rst(rst),
		.cnt(cnt)
	);

	// ==========================================================
	// DMA start control: a write that sets the bit wins over a same-cycle done, mismatch or halt clear, but a reset wins over the write
	always_comb begin
		dma_start_nxt = dma_start_r;
		if (dma_start_r && (dma_done || mismatch_abort || (!initiator_mode && dma_halt))) begin
			dma_start_nxt = 1'b0; // [R3]
		end
		if (wr_hit) begin
			dma_start_nxt = reg_wdata[stc_pkg::STC_DMA_START_BIT]; // [R2]
		end
		if (any_reset) begin
			dma_start_nxt = 1'b0; // [R1]
		end
	end

	// ==========================================================
	// Direction control, shared by both transfer kinds
	always_comb begin
		direction_nxt = direction_r;
		if (wr_hit) begin
			direction_nxt = reg_wdata[stc_pkg::STC_DIRECTION_BIT]; // [R6]
		end
		if (any_reset) begin
			direction_nxt = 1'b0; // [R1]
		end
	end

	// ==========================================================
	// Programmed transfer start bit and its sequencer
	always_comb begin
		pio_start_nxt = pio_start_r;
		pio_state_nxt = pio_state_r;
		case (pio_state_r)
			stc_pkg::STC_PIO_IDLE: begin
				if (pio_start_r) begin
					pio_state_nxt = stc_pkg::STC_PIO_RUN; // [R4]
				end
			end
			stc_pkg::STC_PIO_RUN: begin
				if (pio_finish || mismatch_abort || !pio_start_r) begin
					pio_start_nxt = 1'b0; // [R5]
					pio_state_nxt = stc_pkg::STC_PIO_IDLE;
				end
			end
			default: begin
				pio_start_nxt = 1'b0;
				pio_state_nxt = stc_pkg::STC_PIO_IDLE;
			end
		endcase
		// A new write restarts from the freshly loaded count
		if (wr_hit) begin
			pio_start_nxt = reg_wdata[stc_pkg::STC_PIO_START_BIT]; // [R4]
			pio_state_nxt = stc_pkg::STC_PIO_IDLE;
		end
		if (any_reset) begin
			pio_start_nxt = 1'b0; // [R1]
			pio_state_nxt = stc_pkg::STC_PIO_IDLE;
		end
	end

	// ==========================================================
	// Read data: the count field shows the running count, not the written one
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_hit) begin
			rdata_nxt = stc_pkg::STC_TRANSFER_CONTROL_RESET;
			rdata_nxt[stc_pkg::STC_DMA_START_BIT] = dma_start_r;
			rdata_nxt[stc_pkg::STC_PIO_START_BIT] = pio_start_r;
			rdata_nxt[stc_pkg::STC_DIRECTION_BIT] = direction_r;
			rdata_nxt[stc_pkg::STC_COUNT_MSB:stc_pkg::STC_COUNT_LSB] = cnt.count; // [R7]
		end else if (reg_read) begin
			rdata_nxt = 8'h00; // Other addresses belong to other blocks
		end
	end

	// ==========================================================
	// SCSI drivers float for as long as the software reset is held
	always_comb begin
		drive_en_nxt = !host_buffer_reset; // [R9]
	end

	// ==========================================================
	// State registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dma_start_r <= 1'b0;
			pio_start_r <= 1'b0;
			direction_r <= 1'b0;
			pio_state_r <= stc_pkg::STC_PIO_IDLE;
			rdata_r <= stc_pkg::STC_TRANSFER_CONTROL_RESET;
			drive_en_r <= 1'b0; // Floated until reset is released
		end else begin
			dma_start_r <= dma_start_nxt;
			pio_start_r <= pio_start_nxt;
			direction_r <= direction_nxt;
			pio_state_r <= pio_state_nxt;
			rdata_r <= rdata_nxt;
			drive_en_r <= drive_en_nxt;
		end
	end

	// ==========================================================
	// Outputs straight from flip-flops
	assign reg_rdata = rdata_r;
	assign dma_active = dma_start_r; // [R2]
	assign pio_active = pio_start_r; // [R4]
	assign bus_transfer_direction = direction_r; // [R6]
	assign scsi_drive_enable = drive_en_r; // [R9]
endmodule
`default_nettype wire

/* File: verif/stc_far_model.sv */
// Far-side SCSI peer model that paces bytes and ends DMA runs
`timescale 1ns/1ps
`default_nettype none
module stc_far_model (
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic pio_active,
	input wire logic dma_active,
	output logic byte_done,
	output logic dma_done
);
	// ==========
	// Pacing
	logic [3:0] gap;
	initial begin
		gap = 4'h0;
		byte_done = 1'b0;
		dma_done = 1'b0;
	end
	// A slow peer waits four cycles per byte, so aborts can land first
	always @(posedge sys_clk) begin
		gap <= (pio_active || dma_active) ? gap + 4'h1 : 4'h0;
		byte_done <= pio_active && (slow ? gap[1:0] == 2'h3 : gap[0]);
		dma_done <= dma_active && gap == (slow ? 4'hf : 4'h4);
	end
endmodule
`default_nettype wire

/* File: verif/stc_transfer_control_monitor.sv */
// Checker bound to the transfer control block
`timescale 1ns/1ps
`default_nettype none
module stc_transfer_control_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic scsi_bus_reset,
	input wire logic host_buffer_reset,
	input wire logic initiator_mode,
	input wire logic phase_mismatch,
	input wire logic scsi_request,
	input wire logic dma_halt,
	input wire logic dma_done,
	input wire logic dma_active,
	input wire logic pio_active,
	input wire logic bus_transfer_direction,
	input wire logic scsi_drive_enable
);
	// ==========
	// Properties
	// Resets refuse writes, so a write only counts with both resets low
	wire rs = scsi_bus_reset | host_buffer_reset;
	wire wr = reg_write & (reg_addr == 8'h52) & !rs;
	wire mis = initiator_mode & phase_mismatch & scsi_request;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_reset_clears: assert property (
		rs |=> !dma_active && !pio_active && !bus_transfer_direction)
		else $error("reset left a bit set");
	a_drive_float: assert property (
		!rst |=> scsi_drive_enable == !$past(host_buffer_reset))
		else $error("drive enable wrong");
	a_dma_launch: assert property (wr && reg_wdata[1] |=> dma_active)
		else $error("dma not started");
	a_pio_launch: assert property (wr && reg_wdata[2] |=> pio_active)
		else $error("pio not started");
	a_dir_follows: assert property (
		wr |=> bus_transfer_direction == $past(reg_wdata[3]))
		else $error("direction wrong");
	a_dma_abort: assert property (
		!wr && (dma_done || mis || !initiator_mode && dma_halt) |=> !dma_active)
		else $error("dma not cleared");
	a_pio_abort: assert property (
		!wr && !$past(wr) && $past(pio_active) && mis |=> !pio_active)
		else $error("pio not aborted");
	a_unmapped_zero: assert property (
		reg_read && reg_addr != 8'h52 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind stc_transfer_control stc_transfer_control_monitor mon (.sys_clk, .rst, .reg_addr,
	.reg_write, .reg_read, .reg_wdata, .reg_rdata, .scsi_bus_reset, .host_buffer_reset,
	.initiator_mode, .phase_mismatch, .scsi_request, .dma_halt, .dma_done, .dma_active,
	.pio_active, .bus_transfer_direction, .scsi_drive_enable);
`default_nettype wire

/* File: verif/test_scsi_transfer_control.sv */
// Self-checking bench for the transfer control block
`timescale 1ns/1ps
`default_nettype none
module test_scsi_transfer_control;
	logic sys_clk, rst, reg_write, reg_read, scsi_bus_reset, host_buffer_reset, slow, rd_d;
	logic initiator_mode, phase_mismatch, scsi_request, dma_halt, byte_done, dma_done;
	logic dma_active, pio_active, bus_transfer_direction, scsi_drive_enable;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
	logic [7:0] exp_q[$];
	int failures, tests_run, nb, k;
	integer seed = 32'h8598122b;
	stc_transfer_control dut (.sys_clk, .rst, .reg_addr, .reg_write, .reg_read, .reg_wdata,
		.reg_rdata, .scsi_bus_reset, .host_buffer_reset, .initiator_mode, .phase_mismatch,
		.scsi_request, .dma_halt, .dma_done, .byte_done, .dma_active, .pio_active,
		.bus_transfer_direction, .scsi_drive_enable);
	stc_far_model peer (.sys_clk, .slow, .pio_active, .dma_active, .byte_done, .dma_done);
	// ==========
	// Clock and tasks
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= 8'h52;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_read <= 1'b0;
	endtask
	// Bounded wait for both starts to drop; a hang ends the run
	task automatic wt();
		for (k = 0; k < 100 && (k == 0 || pio_active || dma_active); k++) @(posedge sys_clk);
		if (k == 100) begin
			failures++;
			complete_run();
		end
	endtask
	// Read answers land one edge after the strobe; bytes count only while started
	always @(posedge sys_clk) begin
		rd_d <= reg_read;
		if (rd_d) chk(reg_rdata, exp_q.pop_front());
		if (byte_done && pio_active) nb++;
	end
	// ==========
	// Scenarios
	initial begin
		{reg_write, reg_read, scsi_bus_reset, host_buffer_reset, dma_halt, slow, rd_d} = '0;
		{initiator_mode, phase_mismatch, scsi_request, reg_addr, reg_wdata} = '0;
		{failures, tests_run, nb} = '0;
		rst = 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h52, 8'h00);
		rd(8'h53, 8'h00);
		// The firmware here never holds a FIFO clear, so every transfer may use the FIFO
		// Idle loads read back as written, counts 0 and 15 first
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			v[2:0] = 3'h0;
			if (i < 2) v[7:4] = {4{i[0]}};
			wr(v);
			rd(8'h52, v);
		end
		// Programmed runs: 3 bytes, empty count, 15 bytes from a slow peer
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 8'h3c : (i == 1) ? 8'h04 : 8'hf4;
			slow <= (i == 2);
			nb = 0;
			wr(v);
			wt();
			chk(nb[7:0], {4'h0, v[7:4]});
			rd(8'h52, {4'h0, v[3], 3'h0});
		end
		// Initiator phase change with request up drops both starts, count kept
		{initiator_mode, scsi_request} <= 2'b11;
		wr(8'hf6);
		phase_mismatch <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk({6'h0, dma_active, pio_active}, 8'h00);
		{initiator_mode, phase_mismatch} <= 2'b00;
		rd(8'h52, 8'hf0);
		// Target mode: dma_halt stops a slow DMA before the peer ends it
		wr(8'h0a);
		dma_halt <= 1'b1;
		@(posedge sys_clk);
		dma_halt <= 1'b0;
		@(posedge sys_clk);
		chk({7'h0, dma_active}, 8'h00);
		// Initiator ignores halt; a mismatch only aborts once request is up
		{initiator_mode, dma_halt, phase_mismatch, scsi_request} <= 4'b1110;
		wr(8'h02);
		repeat (2) @(posedge sys_clk);
		chk({7'h0, dma_active}, 8'h01);
		scsi_request <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk({7'h0, dma_active}, 8'h00);
		{initiator_mode, dma_halt, phase_mismatch} <= 3'b000;
		slow <= 1'b0;
		wr(8'h02);
		wt();
		rd(8'h52, 8'h00);
		// Bus reset then soft reset mid-run; writes during them are refused
		for (int j = 0; j < 2; j++) begin
			wr(8'hfe);
			{host_buffer_reset, scsi_bus_reset} <= j[0] ? 2'b10 : 2'b01;
			wr(8'h0e);
			chk({7'h0, scsi_drive_enable}, {7'h0, !j[0]});
			{host_buffer_reset, scsi_bus_reset} <= 2'b00;
			rd(8'h52, 8'h00);
		end
		repeat (3) @(posedge sys_clk);
		complete_run();
	end
endmodule
`default_nettype wire
